// File: verilog/strap_led_polarity.sv
// top of the strap capture and port indicator block
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module strap_led_polarity
(
   // clock and reset
   input  wire logic                                clk_sys,
   input  wire logic                                srst,
   // register port
   input  wire logic [strap_led_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [strap_led_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic      [strap_led_pkg::DATA_W-1:0]    reg_rdata,
   // strap enables from package and configuration
   input  wire logic                                swap_strap_en,
   input  wire logic                                gang_strap_en,
   input  wire logic                                drive_strap_en,
   // primary indicator pins, port 1 in bit 0
   input  wire logic [3:0]                          primary_port_indicator_in,
   output logic      [3:0]                          primary_port_indicator_out,
   output logic      [3:0]                          primary_port_indicator_oe_n,
   // secondary indicator pins, ports 1 and 2
   input  wire logic [1:0]                          secondary_indicator_p12_in,
   output logic      [1:0]                          secondary_indicator_p12_out,
   output logic      [1:0]                          secondary_indicator_p12_oe_n,
   // secondary indicator pin, port 3
   input  wire logic                                secondary_indicator_p3_in,
   output logic                                     secondary_indicator_p3_out,
   output logic                                     secondary_indicator_p3_oe_n,
   // secondary indicator pin, port 4
   input  wire logic                                secondary_indicator_p4_in,
   output logic                                     secondary_indicator_p4_out,
   output logic                                     secondary_indicator_p4_oe_n,
   // latched settings for the port logic and phys
   output logic      [3:0]                          pair_swap_strap,
   output logic                                     gang_mode,
   output logic      [1:0]                          phy_drive_current_field
);

   // =====================================================
   // internal state
   strap_if st ();

   logic       led_en;
   logic [7:0] lamp_on;
   logic [7:0] pin_level;
   logic [7:0] pin_out;
   logic [7:0] pin_oe_n;
   logic       drive_pins;
   logic [strap_led_pkg::DATA_W-1:0] next_rdata;

   // =====================================================
   // address decode, shared by read and write paths
   function automatic logic hit(input logic [strap_led_pkg::ADDR_W-1:0] addr,
                                input logic [7:0]                      offset);
      hit = (addr == offset);
   endfunction

   // gather the eight shared pins into one vector, primary first
   assign pin_level = {secondary_indicator_p4_in,
                       secondary_indicator_p3_in,
                       secondary_indicator_p12_in,
                       primary_port_indicator_in};

   // =====================================================
   // strap capture
   strap_capture u_capture
   (
      .clk_sys        (clk_sys),
      .srst           (srst),
      .swap_strap_en  (swap_strap_en),
      .gang_strap_en  (gang_strap_en),
      .drive_strap_en (drive_strap_en),
      .pin_level      (pin_level),
      .st             (st.latch)
   );

   // latched settings leave straight from the capture flops
   assign pair_swap_strap         = st.swap;
   assign gang_mode               = st.gang;
   assign phy_drive_current_field = st.drive;

   // =====================================================
   // control register: indicator support switch
   // stands for the enable that the configuration memory or management bus would load
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         led_en <= strap_led_pkg::CTRL_LED_EN_RST;
      else if (reg_wr && hit(reg_addr, strap_led_pkg::REG_CTRL))
         led_en <= reg_wdata[strap_led_pkg::CTRL_LED_EN_BIT];
   end

   // lamp register: one logical on bit per pin, polarity applied later
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         lamp_on <= strap_led_pkg::LAMP_RST;
      else if (reg_wr && hit(reg_addr, strap_led_pkg::REG_LAMP))
         lamp_on <= reg_wdata[7:0];
   end

   // =====================================================
   // read mux; unmapped offsets and idle cycles read as zero
   always_comb
   begin
      next_rdata = '0;
      if (reg_rd)
      begin
         if (hit(reg_addr, strap_led_pkg::REG_CTRL))
            next_rdata[strap_led_pkg::CTRL_LED_EN_BIT] = led_en;
         else if (hit(reg_addr, strap_led_pkg::REG_LAMP))
            next_rdata[7:0] = lamp_on;
         else if (hit(reg_addr, strap_led_pkg::REG_STRAP))
         begin
            next_rdata[strap_led_pkg::STRAP_SWAP_LSB +: 4]  = st.swap;
            next_rdata[strap_led_pkg::STRAP_GANG_BIT]       = st.gang;
            next_rdata[strap_led_pkg::STRAP_DRIVE_LSB +: 2] = st.drive;
            next_rdata[strap_led_pkg::STRAP_DONE_BIT]       = st.captured;
         end
         else if (hit(reg_addr, strap_led_pkg::REG_POLARITY))
            next_rdata[7:0] = st.active_low;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         reg_rdata <= '0;
      else
         reg_rdata <= next_rdata;
   end

   // =====================================================
   // pin drivers
   // pins stay released until the straps are in, so board pulls are never fought
   assign drive_pins = led_en && st.captured;

   indicator_drive #(.WIDTH(strap_led_pkg::NUM_PINS)) u_drive
   (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .enable     (drive_pins),
      .lamp_on    (lamp_on),
      .active_low (st.active_low),
      .pin_out    (pin_out),
      .pin_oe_n   (pin_oe_n)
   );

   // split the driver vector back onto the named pins
   assign primary_port_indicator_out   = pin_out[3:0];
   assign primary_port_indicator_oe_n  = pin_oe_n[3:0];
   assign secondary_indicator_p12_out  = pin_out[5:4];
   assign secondary_indicator_p12_oe_n = pin_oe_n[5:4];
   assign secondary_indicator_p3_out   = pin_out[6];
   assign secondary_indicator_p3_oe_n  = pin_oe_n[6];
   assign secondary_indicator_p4_out   = pin_out[7];
   assign secondary_indicator_p4_oe_n  = pin_oe_n[7];

   // =====================================================
   // checks
   // reset keeps every pin released
   pins_released_a: assert property (@(posedge clk_sys) srst |=> pin_oe_n == strap_led_pkg::PINS_RELEASED)
      else $error("indicator pin driven during or right after reset");

   // swap straps follow the pins at the release edge
   swap_capture_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($past(srst) && swap_strap_en) |=> pair_swap_strap == $past(primary_port_indicator_in))
      else $error("pair swap strap not taken at reset release");

   // gang strap follows its pin at the release edge
   gang_capture_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($past(srst) && gang_strap_en) |=> gang_mode == $past(secondary_indicator_p3_in))
      else $error("gang strap not taken at reset release");

   // drive field follows both pins at the release edge
   drive_capture_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($past(srst) && drive_strap_en) |=> phy_drive_current_field == $past(secondary_indicator_p12_in))
      else $error("drive field not taken at reset release");

   // latched straps never move between resets
   strap_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
      (st.captured && $past(st.captured)) |-> ($stable(pair_swap_strap) && $stable(gang_mode)
                                               && $stable(phy_drive_current_field)))
      else $error("strap value changed without reset");

   // primary pins drive at the swap level one edge after enable
   // a strap left unsampled keeps its lamp active low; the enables are static board options
   primary_level_a: assert property (@(posedge clk_sys) disable iff (srst)
      drive_pins |=> (primary_port_indicator_oe_n == 4'h0)
                     && (primary_port_indicator_out ==
                         ($past(lamp_on[3:0]) ^ (pair_swap_strap | {4{!swap_strap_en}}))))
      else $error("primary indicator level wrong");

   // port four secondary lamp is always active low
   p4_level_a: assert property (@(posedge clk_sys) disable iff (srst)
      drive_pins |=> !secondary_indicator_p4_oe_n && (secondary_indicator_p4_out == !$past(lamp_on[7])))
      else $error("port four secondary level wrong");

   // port three secondary lamp follows the gang strap
   p3_level_a: assert property (@(posedge clk_sys) disable iff (srst)
      drive_pins |=> !secondary_indicator_p3_oe_n
                     && (secondary_indicator_p3_out == ($past(lamp_on[6]) ^ (gang_mode | !gang_strap_en))))
      else $error("port three secondary level wrong");

   // ports one and two secondary lamps follow the drive code bits
   p12_level_a: assert property (@(posedge clk_sys) disable iff (srst)
      drive_pins |=> (secondary_indicator_p12_oe_n == 2'h0)
                     && (secondary_indicator_p12_out ==
                         ($past(lamp_on[5:4]) ^ (phy_drive_current_field | {2{!drive_strap_en}}))))
      else $error("port one or two secondary level wrong");

   // no pin drives while support is off
   support_off_a: assert property (@(posedge clk_sys) disable iff (srst)
      !led_en |=> pin_oe_n == strap_led_pkg::PINS_RELEASED)
      else $error("indicator driven with support off");

   // secondary pins of ports one and two light when support comes on
   p12_enable_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(drive_pins) |=> (secondary_indicator_p12_oe_n == 2'h0) [*2])
      else $error("port one or two secondary not driven");

endmodule

// File: verilog/strap_led_pkg.sv
// constants, field positions and types for the strap and indicator block
// ============================================================
// How it works
// - with indicator support switched on, each primary pin lights its own port at the level its strap chose.
// - with its strap enabled, each primary pin is sampled at reset release to set that port's pair order.
// - a swap strap of 0 keeps the pair normal with an active-high lamp, 1 swaps it with an active-low lamp.
// - the port four secondary pin lights that port, always active low, once indicator support is on.
// - the port three secondary pin lights that port once support is on, at the level of the gang strap.
// - with its strap enabled, the port three secondary pin is sampled at reset release to pick gang mode.
// - a gang strap of 0 means per-port switching and an active-high lamp, 1 means ganged and active low.
// - the port one and two secondary pins light those ports once indicator support is on.
// - with its strap enabled, the port one and two secondary pins form a two-bit code copied to the drive field.
// - the upper code bit sets the port two lamp level and the lower bit port one, 0 high and 1 low.
// ============================================================
package strap_led_pkg;

   // bus geometry
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned NUM_PORTS = 4;
   localparam int unsigned NUM_PINS  = 8;

   // register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_LAMP     = 8'h04;
   localparam logic [7:0] REG_STRAP    = 8'h08;
   localparam logic [7:0] REG_POLARITY = 8'h0C;

   // field positions
   localparam int unsigned CTRL_LED_EN_BIT = 0;
   localparam int unsigned STRAP_SWAP_LSB  = 0;
   localparam int unsigned STRAP_GANG_BIT  = 4;
   localparam int unsigned STRAP_DRIVE_LSB = 5;
   localparam int unsigned STRAP_DONE_BIT  = 8;

   // pin slots in the eight-wide indicator vector
   localparam int unsigned PIN_PRI_LSB = 0;
   localparam int unsigned PIN_SEC_P1  = 4;
   localparam int unsigned PIN_SEC_P2  = 5;
   localparam int unsigned PIN_SEC_P3  = 6;
   localparam int unsigned PIN_SEC_P4  = 7;

   // reset and default values
   localparam logic       CTRL_LED_EN_RST = 1'b0;
   localparam logic [7:0] LAMP_RST        = 8'h00;
   localparam logic       STRAP_DEFAULT   = 1'b0;
   localparam logic       POL_DEFAULT     = 1'b1;
   localparam logic [7:0] PINS_RELEASED   = 8'hFF;

   // capture sequencer
   typedef enum logic [1:0] {
      ST_HOLD = 2'b01,
      ST_RUN  = 2'b10
   } cap_state_t;

endpackage

// File: verilog/strap_if.sv
// carrier for latched strap values between the capture unit and the top
`timescale 1ns/100ps
interface strap_if;
   logic [3:0] swap;
   logic       gang;
   logic [1:0] drive;
   logic [7:0] active_low;
   logic       captured;

   modport latch (output swap, output gang, output drive, output active_low, output captured);
   modport user  (input swap, input gang, input drive, input active_low, input captured);
endinterface

// File: verilog/strap_capture.sv
// samples the shared pins once at reset release and holds the result
`timescale 1ns/100ps
module strap_capture
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // strap enables from package and configuration
   input  wire logic       swap_strap_en,
   input  wire logic       gang_strap_en,
   input  wire logic       drive_strap_en,
   // raw pin levels, primary in 3:0 then secondary p1..p4
   input  wire logic [7:0] pin_level,
   // latched results
   strap_if.latch          st
);
   strap_led_pkg::cap_state_t state;

   // =====================================================
   // capture sequencer
   // one sample per reset; pins are released so the board pulls decide the level
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state         <= strap_led_pkg::ST_HOLD;
         st.captured   <= 1'b0;
         st.swap       <= {4{strap_led_pkg::STRAP_DEFAULT}};
         st.gang       <= strap_led_pkg::STRAP_DEFAULT;
         st.drive      <= {2{strap_led_pkg::STRAP_DEFAULT}};
         st.active_low <= {8{strap_led_pkg::POL_DEFAULT}};
      end
      else
      begin
         case (state)
            strap_led_pkg::ST_HOLD:
            begin
               // first edge after release: take every enabled strap
               st.captured <= 1'b1;
               if (swap_strap_en)
               begin
                  st.swap          <= pin_level[3:0];
                  st.active_low[3:0] <= pin_level[3:0];
               end
               if (gang_strap_en)
               begin
                  st.gang                                <= pin_level[strap_led_pkg::PIN_SEC_P3];
                  st.active_low[strap_led_pkg::PIN_SEC_P3] <= pin_level[strap_led_pkg::PIN_SEC_P3];
               end
               if (drive_strap_en)
               begin
                  st.drive <= pin_level[strap_led_pkg::PIN_SEC_P2:strap_led_pkg::PIN_SEC_P1];
                  st.active_low[strap_led_pkg::PIN_SEC_P2:strap_led_pkg::PIN_SEC_P1] <=
                     pin_level[strap_led_pkg::PIN_SEC_P2:strap_led_pkg::PIN_SEC_P1];
               end
               state <= strap_led_pkg::ST_RUN;
            end
            strap_led_pkg::ST_RUN:
               state <= strap_led_pkg::ST_RUN;
            default:
               state <= strap_led_pkg::ST_HOLD;
         endcase
      end
   end
endmodule

// File: verilog/indicator_drive.sv
// registered indicator pin drivers with per-pin polarity
`timescale 1ns/100ps
module indicator_drive
#(
   parameter int unsigned WIDTH = 8
)
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             srst,
   // control
   input  wire logic             enable,
   input  wire logic [WIDTH-1:0] lamp_on,
   input  wire logic [WIDTH-1:0] active_low,
   // pins
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe_n
);
   // =====================================================
   // pin level is the lamp bit flipped for active-low pins
   always_ff @(posedge clk_sys)
   begin
      if (srst || !enable)
      begin
         pin_out  <= '0;
         pin_oe_n <= '1;
      end
      else
      begin
         pin_out  <= lamp_on ^ active_low;
         pin_oe_n <= '0;
      end
   end
endmodule

// File: tb/board_straps.sv
// board model: strap pull resistors and indicator lamps on the shared pins
`timescale 1ns/100ps
module board_straps
(
   // strap pull levels chosen by the bench
   input  wire logic [7:0] pull,
   // design side of the pins, slot order 0-3 primary, 4-7 secondary p1..p4
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   // level seen back at the pins
   output logic      [7:0] pin_in
);
   // ============================================================
   // pin resolution
   // a released pin falls back to its pull resistor, never to a stale drive
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         pin_in[i] = pin_oe_n[i] ? pull[i] : pin_out[i];
   end
endmodule

// File: tb/test_strap_led_polarity.sv
// self-checking bench for the strap capture and indicator block
`timescale 1ns/100ps
module test_strap_led_polarity;
   // ============================================================
   // signals
   logic        clk_sys   = 1'b0;
   logic        srst      = 1'b1;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [31:0] reg_rdata;
   logic [2:0]  strap_en  = 3'h7;  // swap, gang, drive
   logic [7:0]  pull      = 8'h00;
   logic [7:0]  pin_in;
   wire  [7:0]  pin_out;
   wire  [7:0]  pin_oe_n;
   logic [3:0]  pair_swap_strap;
   logic        gang_mode;
   logic [1:0]  phy_drive_current_field;
   int          miscompares = 0;
   int          checked     = 0;
   logic [31:0] seed        = 32'h00016493;

   // clock, 100 ns period
   always #50 clk_sys = ~clk_sys;

   // ============================================================
   // design and board
   strap_led_polarity i_strap_led_polarity
   (
      .clk_sys                      (clk_sys),
      .srst                         (srst),
      .reg_addr                     (reg_addr),
      .reg_wdata                    (reg_wdata),
      .reg_wr                       (reg_wr),
      .reg_rd                       (reg_rd),
      .reg_rdata                    (reg_rdata),
      .swap_strap_en                (strap_en[0]),
      .gang_strap_en                (strap_en[1]),
      .drive_strap_en               (strap_en[2]),
      .primary_port_indicator_in    (pin_in[3:0]),
      .primary_port_indicator_out   (pin_out[3:0]),
      .primary_port_indicator_oe_n  (pin_oe_n[3:0]),
      .secondary_indicator_p12_in   (pin_in[5:4]),
      .secondary_indicator_p12_out  (pin_out[5:4]),
      .secondary_indicator_p12_oe_n (pin_oe_n[5:4]),
      .secondary_indicator_p3_in    (pin_in[6]),
      .secondary_indicator_p3_out   (pin_out[6]),
      .secondary_indicator_p3_oe_n  (pin_oe_n[6]),
      .secondary_indicator_p4_in    (pin_in[7]),
      .secondary_indicator_p4_out   (pin_out[7]),
      .secondary_indicator_p4_oe_n  (pin_oe_n[7]),
      .pair_swap_strap              (pair_swap_strap),
      .gang_mode                    (gang_mode),
      .phy_drive_current_field      (phy_drive_current_field)
   );

   board_straps i_board_straps
   (
      .pull     (pull),
      .pin_out  (pin_out),
      .pin_oe_n (pin_oe_n),
      .pin_in   (pin_in)
   );

   // ============================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // disabled straps leave their lamp active low, port 4 is always low
   function automatic logic [7:0] exp_al(input logic [7:0] p, input logic [2:0] en);
      logic [7:0] a;
      a[3:0] = en[0] ? p[3:0] : 4'hF;
      a[5:4] = en[2] ? p[5:4] : 2'h3;
      a[6]   = en[1] ? p[6] : 1'b1;
      a[7]   = 1'b1;
      return a;
   endfunction

   // strap word: swap, gang, drive, captured flag in bit 8
   function automatic logic [31:0] exp_strap(input logic [7:0] p, input logic [2:0] en);
      return {23'h000000, 1'b1, 1'b0, (en[2] ? p[5:4] : 2'h0), (en[1] & p[6]), (en[0] ? p[3:0] : 4'h0)};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ============================================================
   // watchdog, far beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      conclude();
   end

   // main sequence: corners first, then random straps, each under a fresh reset
   initial
   begin
      logic [7:0]  p;
      logic [7:0]  lamp;
      logic [7:0]  al;
      logic [2:0]  en;
      logic [31:0] d;
      logic [31:0] es;
      repeat (10) @(posedge clk_sys);
      for (int it = 0; it < 12; it++)
      begin
         seed = lfsr(lfsr(lfsr(seed)));
         p    = (it == 0) ? 8'h00 : (it < 3) ? 8'hFF : {seed[7:6], 2'(it), seed[3:0]};
         en   = (it == 1) ? 3'h0 : (it < 6) ? 3'h7 : seed[10:8];
         lamp = seed[23:16];
         al   = exp_al(p, en);
         es   = exp_strap(p, en);
         @(posedge clk_sys);
         srst     <= 1'b1;
         pull     <= p;
         strap_en <= en;
         repeat (2) @(posedge clk_sys);
         #1 check({24'h000000, pin_oe_n}, 32'h000000FF);
         check({24'h000000, pin_out}, 32'h00000000);
         @(posedge clk_sys);
         srst <= 1'b0;
         repeat (3) @(posedge clk_sys);
         pull <= ~p;  // later pin changes must not reach the latches
         #1 check({28'h0000000, pair_swap_strap}, {28'h0000000, es[3:0]});
         check({31'h00000000, gang_mode}, {31'h00000000, es[4]});
         check({30'h00000000, phy_drive_current_field}, {30'h00000000, es[6:5]});
         rd(strap_led_pkg::REG_STRAP, d);
         check(d, es);
         // read data must fall back to zero one cycle later
         @(posedge clk_sys);
         #1 check(reg_rdata, 32'h00000000);
         rd(strap_led_pkg::REG_POLARITY, d);
         check(d, {24'h000000, al});
         wr(strap_led_pkg::REG_STRAP, 32'hFFFFFFFF);
         rd(strap_led_pkg::REG_STRAP, d);
         check(d, es);
         rd(8'h10, d);
         check(d, 32'h00000000);
         wr(strap_led_pkg::REG_LAMP, {24'h000000, lamp});
         wr(strap_led_pkg::REG_CTRL, 32'h00000001);
         @(posedge clk_sys);
         #1 check({24'h000000, pin_oe_n}, 32'h00000000);
         check({28'h0000000, pin_out[3:0]}, {28'h0000000, lamp[3:0] ^ al[3:0]});
         check({30'h00000000, pin_out[5:4]}, {30'h00000000, lamp[5:4] ^ al[5:4]});
         check({31'h00000000, pin_out[6]}, {31'h00000000, lamp[6] ^ al[6]});
         check({31'h00000000, pin_out[7]}, {31'h00000000, ~lamp[7]});
         check({24'h000000, pin_in}, {24'h000000, lamp ^ al});
         check({23'h000000, 1'b1, 1'b0, phy_drive_current_field, gang_mode, pair_swap_strap}, es);
         // control and lamp words read back as written
         rd(strap_led_pkg::REG_LAMP, d);
         check(d, {24'h000000, lamp});
         rd(strap_led_pkg::REG_CTRL, d);
         check(d, 32'h00000001);
         wr(strap_led_pkg::REG_CTRL, 32'h00000000);
         @(posedge clk_sys);
         #1 check({24'h000000, pin_oe_n}, 32'h000000FF);
         check({24'h000000, pin_in}, {24'h000000, ~p});
      end
      conclude();
   end
endmodule
